//--- design/swp_pkg.sv
// ****************************************************************
// Shared constants and types of the write-protect block
// ****************************************************************
package swp_pkg;

    // ************************************************************
    // Addressing byte layout
    // ************************************************************
    localparam logic [3:0] TYPE_ARRAY = 4'hA;    // Array type identifier
    localparam logic [3:0] TYPE_PROT = 4'h6;     // Protection type identifier
    localparam int TYPE_MSB = 7;                 // Type identifier high bit
    localparam int TYPE_LSB = 4;                 // Type identifier low bit
    localparam int STRAP_MSB = 3;                // Strap-match high bit
    localparam int STRAP_LSB = 1;                // Strap-match low bit
    localparam int RW_BIT = 0;                   // Direction bit, 1 = read
    localparam logic [2:0] SET_REV_STRAPS = 3'h1;   // Straps of set-reversible
    localparam logic [2:0] CLR_REV_STRAPS = 3'h3;   // Straps of clear-reversible

    // ************************************************************
    // Array split
    // ************************************************************
    localparam int HALF_BIT = 7;                 // Word address bit selecting upper half

    // ************************************************************
    // Register port map and reset values
    // ************************************************************
    localparam logic [3:0] REG_STATUS = 4'h0;    // Read-only state
    localparam logic [3:0] REG_PROG_LEN = 4'h4;  // Program cycle length in clocks
    localparam logic [15:0] PROG_LEN_RST = 16'h03E8;  // Program cycle length after reset
    localparam int ST_PERM = 0;                  // Status: permanent flag
    localparam int ST_REV = 1;                   // Status: reversible flag
    localparam int ST_BUSY = 2;                  // Status: program cycle running
    localparam int ST_WP = 3;                    // Status: protect pin level
    localparam int ST_ACK = 4;                   // Status: last address reply
    localparam int ST_HV = 5;                    // Status: strap zero high voltage

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        SWP_IDLE = 4'b0001,                      // Waiting for an addressing byte
        SWP_ARR_WR = 4'b0010,                    // Array write transfer open
        SWP_PROT_WR = 4'b0100,                   // Protection command open
        SWP_BUSY = 4'b1000                       // Self-timed program cycle
    } swp_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,                          // Nothing to program
        OP_SET_PERM = 3'h1,                      // Program permanent flag
        OP_SET_REV = 3'h2,                       // Program reversible flag
        OP_CLR_REV = 3'h3,                       // Clear reversible flag
        OP_ARRAY = 3'h4                          // Program array bytes
    } swp_op_t;

    typedef struct packed {
        logic wr;                                // Write strobe
        logic rd;                                // Read strobe
        logic [3:0] addr;                        // Register byte address
        logic [31:0] wdata;                      // Write data
    } swp_reg_req_t;

    typedef struct packed {
        logic addr_stb;                          // Addressing byte received
        logic [7:0] addr_byte;                   // Its value
        logic data_stb;                          // Data byte received for array
        logic [7:0] word_addr;                   // Array location of that byte
        logic stop_stb;                          // Stop condition seen
    } swp_bus_evt_t;

endpackage

//--- design/swp_write_protect.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Array requests ignored during program cycle
// - Busy from launching Stop until cycle end
// - Software protection blocks only 00h to 7Fh
// - Protect pin high blocks every array location
// - Type 0110 write sets permanent flag
// - Permanent set: NACK 0110 except set-reversible while reversible clear, never clears
// - Byte 62h with high voltage sets reversible
// - Byte 66h with high voltage clears reversible
// - Pin high: acknowledge but never program flags
// - Pin low: permission from stored flags only
// - Flag set: acknowledge, store 80h to FFh only
// - No flag: acknowledge, whole array writable
// - Permanent status read: NACK when set
// - Reversible status read: NACK when set
// - Set reversible when set: NACK, unchanged
// - Clear reversible: NACK if permanent set
// - Permanent clear, pin low: ACK, program it
// - Pin high: acknowledge array writes, discard data
// - Type identifier, three straps, direction bit
// - No addressing acknowledge during program cycle
module swp_write_protect (
    input wire logic clk,                        // 200 MHz clock
    input wire logic srst,                       // Synchronous reset, high
    input wire logic nv_perm_init,               // Stored permanent flag at power-up
    input wire logic nv_rev_init,                // Stored reversible flag at power-up
    input wire logic wp_pin,                     // Hardware protect pin
    input wire logic strap_two,                  // Address strap two
    input wire logic strap_one,                  // Address strap one
    input wire logic strap_zero,                 // Address strap zero logic level
    input wire logic high_voltage_level,         // Strap zero at high voltage
    input wire swp_pkg::swp_bus_evt_t bus_evt,   // Decoded serial bus events
    input wire swp_pkg::swp_reg_req_t reg_req,   // Register port request
    output logic [31:0] reg_rdata,               // Register read data
    output logic ack_valid,                      // Reply to addressing byte ready
    output logic ack,                            // 1 = ACK, 0 = NACK
    output logic arr_wr_stb,                     // Store one array byte
    output logic [7:0] arr_wr_addr,              // Location of that byte
    output logic arr_commit,                     // Array program cycle finished
    output logic nv_prog_stb,                    // Flags programmed into storage
    output logic permanent_protect_flag,         // Permanent flag
    output logic reversible_protect_flag,        // Reversible flag
    output logic busy                            // Program cycle running
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [4:0] pin_meta_r;                      // First stage, read only by second
    logic [4:0] pin_sync_r;                      // Second stage

    // Two flip-flops on every pin
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_r <= 5'h00;
            pin_sync_r <= 5'h00;
        end else begin
            pin_meta_r <= {high_voltage_level, wp_pin, strap_two, strap_one, strap_zero};
            pin_sync_r <= pin_meta_r;
        end
    end

    logic hv_s;                                  // Qualified high voltage on strap zero
    logic wp_s;                                  // Protect pin
    logic [2:0] straps_s;                        // Straps two, one, zero
    assign hv_s = pin_sync_r[4];
    assign wp_s = pin_sync_r[3];
    assign straps_s = pin_sync_r[2:0];

    // ************************************************************
    // State
    // ************************************************************
    swp_pkg::swp_state_t state_r;                // Transfer state
    swp_pkg::swp_state_t state_nxt;              // Next transfer state
    swp_pkg::swp_op_t op_r;                      // Operation to program
    swp_pkg::swp_op_t op_nxt;                    // Next operation
    logic perm_r;                                // Permanent flag
    logic rev_r;                                 // Reversible flag
    logic [15:0] prog_len_r;                     // Program cycle length
    logic [15:0] cnt_r;                          // Program cycle counter
    logic arr_any_r;                             // Some array byte stored

    // ************************************************************
    // Addressing byte decode
    // ************************************************************
    logic [3:0] ab_type;                         // Type identifier of byte
    logic [2:0] ab_straps;                       // Strap bits of byte
    logic ab_rd;                                 // Direction is read
    logic straps_hit;                            // Byte straps match pins
    logic rev_set_hit;                           // Set-reversible pin and byte pattern
    logic rev_clr_hit;                           // Clear-reversible pin and byte pattern
    logic dec_ack;                               // Reply for this byte
    swp_pkg::swp_op_t dec_op;                    // Operation the byte opens
    logic dec_arr;                               // Byte opens array write

    assign ab_type = bus_evt.addr_byte[swp_pkg::TYPE_MSB:swp_pkg::TYPE_LSB];
    assign ab_straps = bus_evt.addr_byte[swp_pkg::STRAP_MSB:swp_pkg::STRAP_LSB];
    assign ab_rd = bus_evt.addr_byte[swp_pkg::RW_BIT];
    assign straps_hit = (ab_straps == straps_s) && !hv_s;
    assign rev_set_hit = hv_s && (ab_straps == swp_pkg::SET_REV_STRAPS)
                         && !straps_s[2] && !straps_s[1];
    assign rev_clr_hit = hv_s && (ab_straps == swp_pkg::CLR_REV_STRAPS)
                         && !straps_s[2] && straps_s[1];

    // Reply and pending operation for one addressing byte
    always_comb begin
        dec_ack = 1'b0;
        dec_op = swp_pkg::OP_NONE;
        dec_arr = 1'b0;
        if (ab_type == swp_pkg::TYPE_ARRAY && straps_hit) begin
            // Array access is acknowledged except during a program cycle
            dec_ack = 1'b1;
            dec_arr = !ab_rd;
        end else if (ab_type == swp_pkg::TYPE_PROT) begin
            if (rev_set_hit) begin
                // Reversible status read or set
                dec_ack = !rev_r;
                if (!ab_rd && !rev_r && !wp_s) begin
                    dec_op = swp_pkg::OP_SET_REV;
                end
            end else if (rev_clr_hit && !ab_rd) begin
                // Clear only while permanent flag is clear
                dec_ack = !perm_r;
                if (!perm_r && !wp_s) begin
                    dec_op = swp_pkg::OP_CLR_REV;
                end
            end else if (straps_hit) begin
                // Permanent status read or set
                dec_ack = !perm_r;
                if (!ab_rd && !perm_r && !wp_s) begin
                    dec_op = swp_pkg::OP_SET_PERM;
                end
            end
        end
    end

    // ************************************************************
    // Array write permission
    // ************************************************************
    logic wr_allow;                              // This data byte may be stored
    // Pin high blocks all; either flag blocks the lower half
    assign wr_allow = !wp_s
                      && (!(perm_r || rev_r)
                          || bus_evt.word_addr[swp_pkg::HALF_BIT]);

    logic cycle_done;                            // Last clock of program cycle
    assign cycle_done = (state_r == swp_pkg::SWP_BUSY) && (cnt_r == 16'h0001);

    // ************************************************************
    // Transfer state machine
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        case (state_r)
            swp_pkg::SWP_IDLE, swp_pkg::SWP_ARR_WR, swp_pkg::SWP_PROT_WR: begin
                if (bus_evt.addr_stb) begin
                    // Repeated start drops anything not yet launched
                    op_nxt = dec_arr ? swp_pkg::OP_ARRAY : dec_op;
                    if (dec_arr) begin
                        state_nxt = swp_pkg::SWP_ARR_WR;
                    end else if (dec_op != swp_pkg::OP_NONE) begin
                        state_nxt = swp_pkg::SWP_PROT_WR;
                    end else begin
                        state_nxt = swp_pkg::SWP_IDLE;
                    end
                end else if (bus_evt.stop_stb) begin
                    // Stop launches the program cycle if work is pending
                    if (state_r == swp_pkg::SWP_PROT_WR
                        || (state_r == swp_pkg::SWP_ARR_WR && arr_any_r)) begin
                        state_nxt = swp_pkg::SWP_BUSY;
                    end else begin
                        state_nxt = swp_pkg::SWP_IDLE;
                        op_nxt = swp_pkg::OP_NONE;
                    end
                end
            end
            swp_pkg::SWP_BUSY: begin
                // Bus requests have no effect here
                if (cycle_done) begin
                    state_nxt = swp_pkg::SWP_IDLE;
                    op_nxt = swp_pkg::OP_NONE;
                end
            end
            default: begin
                state_nxt = swp_pkg::SWP_IDLE;
                op_nxt = swp_pkg::OP_NONE;
            end
        endcase
    end

    // State and operation registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= swp_pkg::SWP_IDLE;
            op_r <= swp_pkg::OP_NONE;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
        end
    end

    // Program cycle counter
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= 16'h0000;
        end else if (state_r != swp_pkg::SWP_BUSY && state_nxt == swp_pkg::SWP_BUSY) begin
            cnt_r <= (prog_len_r == 16'h0000) ? 16'h0001 : prog_len_r;
        end else if (state_r == swp_pkg::SWP_BUSY && cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    // ************************************************************
    // Bus replies and array byte stores
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_valid <= 1'b0;
            ack <= 1'b0;
        end else begin
            ack_valid <= bus_evt.addr_stb;
            if (bus_evt.addr_stb) begin
                // Busy device stays silent so the host can poll
                ack <= (state_r != swp_pkg::SWP_BUSY) && dec_ack;
            end
        end
    end

    // Data bytes that pass the protection check are stored
    always_ff @(posedge clk) begin
        if (srst) begin
            arr_wr_stb <= 1'b0;
            arr_wr_addr <= 8'h00;
            arr_any_r <= 1'b0;
        end else begin
            arr_wr_stb <= 1'b0;
            if (bus_evt.addr_stb && state_r != swp_pkg::SWP_BUSY) begin
                arr_any_r <= 1'b0;
            end else if (bus_evt.data_stb && state_r == swp_pkg::SWP_ARR_WR
                         && wr_allow) begin
                arr_wr_stb <= 1'b1;
                arr_wr_addr <= bus_evt.word_addr;
                arr_any_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Nonvolatile flags
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            // Reload stored state as at power-up
            perm_r <= nv_perm_init;
            rev_r <= nv_rev_init;
            nv_prog_stb <= 1'b0;
            arr_commit <= 1'b0;
        end else begin
            nv_prog_stb <= 1'b0;
            arr_commit <= 1'b0;
            if (cycle_done) begin
                case (op_r)
                    swp_pkg::OP_SET_PERM: begin
                        perm_r <= 1'b1;
                        nv_prog_stb <= 1'b1;
                    end
                    swp_pkg::OP_SET_REV: begin
                        rev_r <= 1'b1;
                        nv_prog_stb <= 1'b1;
                    end
                    swp_pkg::OP_CLR_REV: begin
                        rev_r <= 1'b0;
                        nv_prog_stb <= 1'b1;
                    end
                    swp_pkg::OP_ARRAY: begin
                        arr_commit <= 1'b1;
                    end
                    default: begin
                        arr_commit <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign permanent_protect_flag = perm_r;
    assign reversible_protect_flag = rev_r;
    assign busy = (state_r == swp_pkg::SWP_BUSY);

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            prog_len_r <= swp_pkg::PROG_LEN_RST;
        end else if (reg_req.wr && reg_req.addr == swp_pkg::REG_PROG_LEN) begin
            prog_len_r <= reg_req.wdata[15:0];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    swp_pkg::REG_STATUS: begin
                        reg_rdata[swp_pkg::ST_PERM] <= perm_r;
                        reg_rdata[swp_pkg::ST_REV] <= rev_r;
                        reg_rdata[swp_pkg::ST_BUSY] <= (state_r == swp_pkg::SWP_BUSY);
                        reg_rdata[swp_pkg::ST_WP] <= wp_s;
                        reg_rdata[swp_pkg::ST_ACK] <= ack;
                        reg_rdata[swp_pkg::ST_HV] <= hv_s;
                    end
                    swp_pkg::REG_PROG_LEN: begin
                        reg_rdata[15:0] <= prog_len_r;
                    end
                    default: begin
                        reg_rdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

//--- test/swp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bus host: issues decoded transfers to the device
// ************************************************************
module swp_host_model (
    input wire logic clk, // Clock
    input wire logic ack_valid, // Reply pulse
    input wire logic ack, // Reply level
    output var swp_pkg::swp_bus_evt_t bus_evt // Bus events
);
    initial bus_evt = '0;
    // Addressing byte, n data bytes, then stop or an open transfer
    task automatic xfer(input logic [7:0] ab, input int n, input logic [7:0] wa,
        input logic stop, output logic [1:0] rep);
        @(posedge clk);
        bus_evt.addr_stb <= 1'b1;
        bus_evt.addr_byte <= ab;
        @(posedge clk);
        bus_evt.addr_stb <= 1'b0;
        bus_evt.addr_byte <= ~ab; // Released byte shows no stale value
        #1 rep = {ack_valid, ack};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            bus_evt.data_stb <= 1'b1;
            bus_evt.word_addr <= wa + 8'(i);
        end
        @(posedge clk);
        bus_evt.data_stb <= 1'b0;
        bus_evt.word_addr <= ~bus_evt.word_addr;
        bus_evt.stop_stb <= stop;
        @(posedge clk);
        bus_evt.stop_stb <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/swp_write_protect_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checks of the write-protect block
// ************************************************************
module swp_write_protect_sva (
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire logic wp_pin, // Protect pin
    input wire logic high_voltage_level, // Strap zero high voltage
    input wire swp_pkg::swp_bus_evt_t bus_evt, // Bus events
    input wire logic ack_valid, // Reply pulse
    input wire logic ack, // Reply level
    input wire logic arr_wr_stb, // Array store
    input wire logic [7:0] arr_wr_addr, // Store location
    input wire logic nv_prog_stb, // Flag programmed
    input wire logic permanent_protect_flag, // Permanent flag
    input wire logic reversible_protect_flag, // Reversible flag
    input wire logic busy // Program cycle
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Addressing byte of the protection type
    wire logic prot_byte = bus_evt.addr_byte[7:4] == swp_pkg::TYPE_PROT;
    reply_lat_a: assert property (bus_evt.addr_stb |=> ack_valid)
        else $error("no reply after addressing byte");
    busy_nack_a: assert property (bus_evt.addr_stb && busy |=> !ack)
        else $error("reply ACK during program cycle");
    busy_store_a: assert property (bus_evt.data_stb && busy |=> !arr_wr_stb)
        else $error("array store during program cycle");
    low_half_a: assert property (arr_wr_stb && (permanent_protect_flag ||
        reversible_protect_flag) |-> arr_wr_addr[7])
        else $error("lower half stored while protected");
    pin_block_a: assert property (wp_pin [*4] |-> !arr_wr_stb)
        else $error("array store with protect pin high");
    perm_keep_a: assert property (permanent_protect_flag |=> permanent_protect_flag)
        else $error("permanent flag cleared");
    perm_nack_a: assert property ((!high_voltage_level) [*3] ##0 (bus_evt.addr_stb &&
        prot_byte && permanent_protect_flag) |=> !ack)
        else $error("protection byte ACKed with permanent flag set");
    flag_edge_a: assert property ($changed(reversible_protect_flag) |->
        nv_prog_stb && !busy)
        else $error("reversible flag changed outside cycle end");
    busy_start_a: assert property ($rose(busy) |-> $past(bus_evt.stop_stb))
        else $error("program cycle without stop");
    // Main scenarios reached
    cover property ($fell(busy) && nv_prog_stb);
    cover property (arr_wr_stb && arr_wr_addr[7]);
    cover property (ack_valid && !ack);
endmodule
`default_nettype wire

//--- test/swp_write_protect_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module swp_write_protect_tb_top;
    logic clk = 1'b0; // 200 MHz clock
    logic srst = 1'b1; // Reset
    logic nv_perm_init = 1'b0, nv_rev_init = 1'b0; // Stored flags
    logic wp_pin = 1'b0, strap_two = 1'b0, strap_one = 1'b0; // Pins
    logic strap_zero = 1'b0, high_voltage_level = 1'b0; // Strap zero
    swp_pkg::swp_reg_req_t reg_req = '0; // Register port
    swp_pkg::swp_bus_evt_t bus_evt; // From host model
    logic [31:0] reg_rdata;
    logic ack_valid, ack, arr_wr_stb, arr_commit, nv_prog_stb, busy;
    logic permanent_protect_flag, reversible_protect_flag;
    logic [7:0] arr_wr_addr;
    logic [1:0] rep;
    int errors = 0, samples_checked = 0, n_wr = 0, n_lo = 0, n_cm = 0;
    always #2.5 clk = ~clk;
    swp_write_protect swp_write_protect_i (.clk, .srst, .nv_perm_init, .nv_rev_init,
        .wp_pin, .strap_two, .strap_one, .strap_zero, .high_voltage_level, .bus_evt,
        .reg_req, .reg_rdata, .ack_valid, .ack, .arr_wr_stb, .arr_wr_addr, .arr_commit,
        .nv_prog_stb, .permanent_protect_flag, .reversible_protect_flag, .busy);
    swp_host_model swp_host_model_i (.clk, .ack_valid, .ack, .bus_evt);
    // Count stored bytes, and those in the lower half
    always @(negedge clk) begin
        n_cm += (arr_commit === 1'b1);
        if (arr_wr_stb === 1'b1) begin
            n_wr++;
            n_lo += (arr_wr_addr[7] === 1'b0);
        end
    end
    task chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req.wr <= 1'b1;
        reg_req.addr <= a;
        reg_req.wdata <= d;
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask
    task reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_req.rd <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task xf(input logic [7:0] b, input int n, input logic [7:0] w, input logic s,
        input logic [1:0] e);
        swp_host_model_i.xfer(b, n, w, s, rep);
        chk({30'h0, rep}, {30'h0, e});
    endtask
    // Pin change, then room for the synchronisers
    task pins(input logic w, o, h);
        @(posedge clk);
        wp_pin <= w;
        strap_one <= o;
        high_voltage_level <= h;
        strap_zero <= h;
        repeat (3) @(posedge clk);
    endtask
    // Bounded wait for the program cycle; e < 0 skips the length check
    task idle(input int e);
        int c;
        c = 0;
        #1;
        for (int k = 0; k < 40 && busy === 1'b1; k++) begin
            c++;
            @(posedge clk);
            #1;
        end
        if (busy === 1'b1) begin
            errors++;
            complete_run();
        end
        if (e >= 0) chk(c, e);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        reg_rd(4'h4, 32'h0000_03E8);
        reg_wr(4'h0, 32'hFFFF_FFFF);
        reg_rd(4'h0, 32'h0);
        reg_rd(4'h8, 32'h0);
        reg_wr(4'h4, 32'h5);
        reg_rd(4'h4, 32'h5);
        $display("test registers done");
        xf(8'hA0, 2, 8'h7E, 1'b1, 2'b11);
        chk(n_lo, 2);
        idle(5);
        xf(8'h61, 0, 8'h00, 1'b1, 2'b11);
        pins(1'b0, 1'b0, 1'b1);
        xf(8'h62, 1, 8'h00, 1'b1, 2'b11);
        xf(8'h62, 1, 8'h10, 1'b0, 2'b10);
        chk(n_wr, 2);
        idle(-1);
        chk(reversible_protect_flag, 1);
        xf(8'h63, 0, 8'h00, 1'b1, 2'b10);
        xf(8'h62, 0, 8'h00, 1'b1, 2'b10);
        idle(0);
        $display("test reversible set done");
        pins(1'b0, 1'b0, 1'b0);
        xf(8'hA0, 2, 8'h7F, 1'b1, 2'b11);
        chk(n_wr, 3);
        chk(n_lo, 2);
        idle(5);
        pins(1'b1, 1'b0, 1'b0);
        chk(n_cm, 2);
        xf(8'hA0, 1, 8'h90, 1'b1, 2'b11);
        chk(n_wr, 3);
        idle(0);
        pins(1'b1, 1'b1, 1'b1);
        xf(8'h66, 0, 8'h00, 1'b1, 2'b11);
        idle(0);
        chk(reversible_protect_flag, 1);
        pins(1'b0, 1'b1, 1'b1);
        xf(8'h66, 0, 8'h00, 1'b1, 2'b11);
        idle(5);
        chk(reversible_protect_flag, 0);
        $display("test pin and clear done");
        pins(1'b0, 1'b0, 1'b0);
        xf(8'h60, 1, 8'h55, 1'b1, 2'b11);
        idle(5);
        chk(permanent_protect_flag, 1);
        xf(8'h61, 0, 8'h00, 1'b1, 2'b10);
        xf(8'h60, 0, 8'h00, 1'b1, 2'b10);
        pins(1'b0, 1'b1, 1'b1);
        xf(8'h66, 0, 8'h00, 1'b1, 2'b10);
        pins(1'b0, 1'b0, 1'b0);
        xf(8'hA0, 1, 8'h10, 1'b1, 2'b11);
        chk(n_wr, 3);
        idle(0);
        $display("test permanent done");
        @(posedge clk);
        srst <= 1'b1;
        nv_rev_init <= 1'b1;
        nv_perm_init <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1 chk(permanent_protect_flag, 1);
        chk(reversible_protect_flag, 1);
        $display("test reload done");
        complete_run();
    end
endmodule
bind swp_write_protect swp_write_protect_sva swp_write_protect_sva_i (.clk, .srst, .wp_pin,
    .high_voltage_level, .bus_evt, .ack_valid, .ack, .arr_wr_stb, .arr_wr_addr, .nv_prog_stb,
    .permanent_protect_flag, .reversible_protect_flag, .busy);
`default_nettype wire
